// ===== design/t8pwm_pkg.sv
// package of constants for the 8-bit pwm timer block
// assumes a single 40 MHz clock and an avalon-mm register slave
package t8pwm_pkg;

	// ==========================================================
	// register byte offsets
	localparam logic [4:0] T8PWM_OFS_CTRL = 5'h00;
	localparam logic [4:0] T8PWM_OFS_COUNT = 5'h04;
	localparam logic [4:0] T8PWM_OFS_COMPARE = 5'h08;
	localparam logic [4:0] T8PWM_OFS_STATUS = 5'h0c;
	localparam logic [4:0] T8PWM_OFS_PIN = 5'h10;

	// ==========================================================
	// control field positions
	localparam int T8PWM_CTRL_MODE_LSB = 0;
	localparam int T8PWM_CTRL_COM_LSB = 2;
	localparam int T8PWM_CTRL_CS_LSB = 4;
	localparam int T8PWM_CTRL_ASYNC_BIT = 7;

	// ==========================================================
	// status field positions
	localparam int T8PWM_STAT_OVF_BIT = 0;
	localparam int T8PWM_STAT_CMP_BIT = 1;
	localparam int T8PWM_STAT_UP_BIT = 2;
	localparam int T8PWM_STAT_OC_BIT = 3;

	// ==========================================================
	// reset values
	localparam logic [7:0] T8PWM_CTRL_RESET = 8'h00;
	localparam logic [7:0] T8PWM_COUNT_RESET = 8'h00;
	localparam logic [7:0] T8PWM_COMPARE_RESET = 8'h00;

	// ==========================================================
	// counter limits
	localparam logic [7:0] T8PWM_MAX = 8'hff;
	localparam logic [7:0] T8PWM_BOTTOM = 8'h00;

	// ==========================================================
	// waveform modes and compare output actions
	localparam logic [1:0] T8PWM_MODE_FAST = 2'h3;
	localparam logic [1:0] T8PWM_MODE_PHASE = 2'h1;
	localparam logic [1:0] T8PWM_COM_NONE = 2'h0;
	localparam logic [1:0] T8PWM_COM_TOGGLE = 2'h1;
	localparam logic [1:0] T8PWM_COM_NONINV = 2'h2;
	localparam logic [1:0] T8PWM_COM_INV = 2'h3;

	// ==========================================================
	// prescale divisors by clock select code, 0 means stopped
	localparam int T8PWM_DIV_WIDTH = 10;
	localparam logic [9:0] T8PWM_DIV_1 = 10'h000;
	localparam logic [9:0] T8PWM_DIV_8 = 10'h007;
	localparam logic [9:0] T8PWM_DIV_32 = 10'h01f;
	localparam logic [9:0] T8PWM_DIV_64 = 10'h03f;
	localparam logic [9:0] T8PWM_DIV_128 = 10'h07f;
	localparam logic [9:0] T8PWM_DIV_256 = 10'h0ff;
	localparam logic [9:0] T8PWM_DIV_1024 = 10'h3ff;

endpackage

// ===== design/t8pwm_prescaler.sv
// prescaler producing the timer tick from a base tick
// assumes base_tick is already in the CLK domain
`timescale 1ns/1ps
module t8pwm_prescaler
	import t8pwm_pkg::*;
(
	// clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// control
	input wire logic base_tick,
	input wire logic [2:0] clock_sel,
	// output
	output logic timer_tick
);

	// ==========================================================
	// divisor decode
	function automatic logic [9:0] last_count(input logic [2:0] sel);
		case (sel)
			3'h1: last_count = T8PWM_DIV_1;
			3'h2: last_count = T8PWM_DIV_8;
			3'h3: last_count = T8PWM_DIV_32;
			3'h4: last_count = T8PWM_DIV_64;
			3'h5: last_count = T8PWM_DIV_128;
			3'h6: last_count = T8PWM_DIV_256;
			default: last_count = T8PWM_DIV_1024;
		endcase
	endfunction

	logic [9:0] pre_q;
	logic at_last;

	assign at_last = (pre_q >= last_count(clock_sel));
	assign timer_tick = base_tick && (clock_sel != 3'h0) && at_last;

	// ==========================================================
	// prescale counter
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			pre_q <= 10'h000;
		end else if (clock_sel == 3'h0) begin
			pre_q <= 10'h000;
		end else if (base_tick) begin
			pre_q <= at_last ? 10'h000 : pre_q + 10'h001;
		end
	end

endmodule

// ===== design/t8pwm_top.sv
// 8-bit timer waveform generator, fast and phase correct pwm
// assumes an avalon-mm master on CLK and an oscillator input on OSC_IN
//
// Overview of operation
// - mode field 3 counts single-slope, BOTTOM up to MAX, then restart
// - single-slope field 2: clear output on match, set at BOTTOM
// - single-slope field 3: set output on match, clear at BOTTOM
// - single-slope counter wraps MAX to zero on next tick, output updates then
// - single-slope overflow flag sets whenever counter reaches MAX
// - single-slope period is 256 ticks; tick is clock over 1..1024
// - single-slope compare BOTTOM gives spike; MAX gives constant level
// - single-slope field 1 toggles on every match, 50 percent duty
// - pwm modes double-buffer the compare value; other modes write directly
// - mode field 1 counts dual-slope, up to MAX then down to BOTTOM
// - dual-slope: non-inverting clears up-match, sets down-match; inverting reversed
// - dual-slope is eight bits; counter stays at MAX one tick
// - dual-slope overflow flag sets when counter reaches BOTTOM
// - dual-slope period is 510 ticks with same prescale choices
// - dual-slope compare BOTTOM holds low, MAX holds high, inverted opposite
// - leaving compare MAX gives up-match level at MAX for symmetry
// - a missed upward match still yields its transition at MAX
// - pin driven only while direction bit selects output
// - logic advances only on tick; oscillator may replace clock as source
// - MAX is 0xff and BOTTOM is 0x00
// - compare output field 0 takes no action on match
// - a counter write blocks any match in the following tick
`timescale 1ns/1ps
module t8pwm_top
	import t8pwm_pkg::*;
(
	// clock and reset
	input wire logic CLK,
	input wire logic RESETN,
	// avalon-mm register slave
	input wire logic [4:0] AVS_ADDRESS,
	input wire logic AVS_READ,
	input wire logic AVS_WRITE,
	input wire logic [31:0] AVS_WRITEDATA,
	input wire logic [3:0] AVS_BYTEENABLE,
	output logic [31:0] AVS_READDATA,
	output logic AVS_WAITREQUEST,
	// oscillator tick source
	input wire logic OSC_IN,
	// compare output pin
	output logic OC_PIN_OUT,
	output logic OC_PIN_OE_N
);

	// ==========================================================
	// bus slave handshake
	logic ack_q;
	logic req;
	logic wr_en;
	logic [31:0] rdata_q;

	assign req = AVS_READ || AVS_WRITE;
	assign AVS_WAITREQUEST = req && !ack_q;
	assign wr_en = AVS_WRITE && ack_q && AVS_BYTEENABLE[0];
	assign AVS_READDATA = rdata_q;

	always_ff @(posedge CLK or negedge RESETN) begin
		if (!RESETN) begin
			ack_q <= 1'b0;
		end else begin
			ack_q <= req && !ack_q;
		end
	end

	// ==========================================================
	// software registers
	logic [1:0] mode_q;
	logic [1:0] com_q;
	logic [2:0] cs_q;
	logic async_q;
	logic ddr_q;
	logic [7:0] ocr_buf_q;
	logic [7:0] ocr_q;
	logic [7:0] cnt_q;
	logic up_q;
	logic oc_q;
	logic ovf_q;
	logic cmp_q;
	logic block_q;

	function automatic logic hit(input logic [4:0] a, input logic [4:0] ofs);
		hit = (a == ofs);
	endfunction

	logic wr_ctrl;
	logic wr_cnt;
	logic wr_ocr;
	logic wr_stat;
	logic wr_pin;

	assign wr_ctrl = wr_en && hit(AVS_ADDRESS, T8PWM_OFS_CTRL);
	assign wr_cnt = wr_en && hit(AVS_ADDRESS, T8PWM_OFS_COUNT);
	assign wr_ocr = wr_en && hit(AVS_ADDRESS, T8PWM_OFS_COMPARE);
	assign wr_stat = wr_en && hit(AVS_ADDRESS, T8PWM_OFS_STATUS);
	assign wr_pin = wr_en && hit(AVS_ADDRESS, T8PWM_OFS_PIN);

	always_ff @(posedge CLK or negedge RESETN) begin
		if (!RESETN) begin
			mode_q <= T8PWM_CTRL_RESET[1:0];
			com_q <= T8PWM_CTRL_RESET[3:2];
			cs_q <= T8PWM_CTRL_RESET[6:4];
			async_q <= T8PWM_CTRL_RESET[7];
		end else if (wr_ctrl) begin
			mode_q <= AVS_WRITEDATA[T8PWM_CTRL_MODE_LSB +: 2];
			com_q <= AVS_WRITEDATA[T8PWM_CTRL_COM_LSB +: 2];
			cs_q <= AVS_WRITEDATA[T8PWM_CTRL_CS_LSB +: 3];
			async_q <= AVS_WRITEDATA[T8PWM_CTRL_ASYNC_BIT];
		end
	end

	always_ff @(posedge CLK or negedge RESETN) begin
		if (!RESETN) begin
			ddr_q <= 1'b0;
		end else if (wr_pin) begin
			ddr_q <= AVS_WRITEDATA[0];
		end
	end

	always_ff @(posedge CLK or negedge RESETN) begin
		if (!RESETN) begin
			ocr_buf_q <= T8PWM_COMPARE_RESET;
		end else if (wr_ocr) begin
			ocr_buf_q <= AVS_WRITEDATA[7:0];
		end
	end

	// read data, unmapped offsets read zero
	always_ff @(posedge CLK or negedge RESETN) begin
		if (!RESETN) begin
			rdata_q <= 32'h0000_0000;
		end else if (AVS_READ && !ack_q) begin
			case (AVS_ADDRESS)
				T8PWM_OFS_CTRL: rdata_q <= {24'h000000, async_q, cs_q, com_q, mode_q};
				T8PWM_OFS_COUNT: rdata_q <= {24'h000000, cnt_q};
				T8PWM_OFS_COMPARE: rdata_q <= {24'h000000, ocr_buf_q};
				T8PWM_OFS_STATUS: rdata_q <= {28'h0000000, oc_q, up_q, cmp_q, ovf_q};
				T8PWM_OFS_PIN: rdata_q <= {31'h00000000, ddr_q};
				default: rdata_q <= 32'h0000_0000;
			endcase
		end
	end

	// ==========================================================
	// tick source
	logic osc_s1_q;
	logic osc_s2_q;
	logic osc_s3_q;
	logic base_tick;
	logic tick;

	always_ff @(posedge CLK or negedge RESETN) begin
		if (!RESETN) begin
			osc_s1_q <= 1'b0;
			osc_s2_q <= 1'b0;
			osc_s3_q <= 1'b0;
		end else begin
			osc_s1_q <= OSC_IN;
			osc_s2_q <= osc_s1_q;
			osc_s3_q <= osc_s2_q;
		end
	end

	assign base_tick = async_q ? (osc_s2_q && !osc_s3_q) : 1'b1;

	t8pwm_prescaler u_prescaler (
		.clk(CLK),
		.rst_n(RESETN),
		.base_tick(base_tick),
		.clock_sel(cs_q),
		.timer_tick(tick)
	);

	// ==========================================================
	// counter
	logic fast;
	logic phase;
	logic at_max;
	logic at_bottom;

	assign fast = (mode_q == T8PWM_MODE_FAST);
	assign phase = (mode_q == T8PWM_MODE_PHASE);
	assign at_max = (cnt_q == T8PWM_MAX);
	assign at_bottom = (cnt_q == T8PWM_BOTTOM);

	always_ff @(posedge CLK or negedge RESETN) begin
		if (!RESETN) begin
			cnt_q <= T8PWM_COUNT_RESET;
			up_q <= 1'b1;
		end else if (wr_cnt) begin
			cnt_q <= AVS_WRITEDATA[7:0];
		end else if (tick) begin
			if (phase) begin
				if (up_q && at_max) begin
					up_q <= 1'b0;
					cnt_q <= cnt_q - 8'h01;
				end else if (!up_q && at_bottom) begin
					up_q <= 1'b1;
					cnt_q <= cnt_q + 8'h01;
				end else begin
					cnt_q <= up_q ? cnt_q + 8'h01 : cnt_q - 8'h01;
				end
			end else begin
				up_q <= 1'b1;
				cnt_q <= cnt_q + 8'h01;
			end
		end
	end

	// ==========================================================
	// compare value and match
	logic load_ocr;
	logic match;

	assign load_ocr = (fast && tick && at_max) || (phase && tick && at_max);

	always_ff @(posedge CLK or negedge RESETN) begin
		if (!RESETN) begin
			ocr_q <= T8PWM_COMPARE_RESET;
		end else if (!fast && !phase) begin
			ocr_q <= ocr_buf_q;
		end else if (load_ocr) begin
			ocr_q <= ocr_buf_q;
		end
	end

	always_ff @(posedge CLK or negedge RESETN) begin
		if (!RESETN) begin
			block_q <= 1'b0;
		end else if (wr_cnt) begin
			block_q <= 1'b1;
		end else if (tick) begin
			block_q <= 1'b0;
		end
	end

	assign match = tick && !block_q && (cnt_q == ocr_q);

	// ==========================================================
	// flags, write one to clear, set wins
	logic ovf_set;

	assign ovf_set = tick && (phase ? at_bottom : at_max);

	always_ff @(posedge CLK or negedge RESETN) begin
		if (!RESETN) begin
			ovf_q <= 1'b0;
		end else if (ovf_set) begin
			ovf_q <= 1'b1;
		end else if (wr_stat && AVS_WRITEDATA[T8PWM_STAT_OVF_BIT]) begin
			ovf_q <= 1'b0;
		end
	end

	always_ff @(posedge CLK or negedge RESETN) begin
		if (!RESETN) begin
			cmp_q <= 1'b0;
		end else if (match) begin
			cmp_q <= 1'b1;
		end else if (wr_stat && AVS_WRITEDATA[T8PWM_STAT_CMP_BIT]) begin
			cmp_q <= 1'b0;
		end
	end

	// ==========================================================
	// waveform
	logic up_level;
	logic pol_ok;

	// level of an up-counting match; down match gives the inverse
	assign up_level = (com_q == T8PWM_COM_INV);
	assign pol_ok = (com_q == T8PWM_COM_NONINV) || (com_q == T8PWM_COM_INV);

	always_ff @(posedge CLK or negedge RESETN) begin
		if (!RESETN) begin
			oc_q <= 1'b0;
		end else if (com_q == T8PWM_COM_NONE) begin
			oc_q <= oc_q;
		end else if (fast) begin
			if (pol_ok && tick && at_max) begin
				oc_q <= !up_level;
			end else if (pol_ok && match) begin
				oc_q <= up_level;
			end else if (com_q == T8PWM_COM_TOGGLE && match) begin
				oc_q <= !oc_q;
			end
		end else if (phase && pol_ok) begin
			if (tick && at_max && up_q) begin
				// MAX gives up level unless compare stays MAX
				oc_q <= (ocr_buf_q == T8PWM_MAX) ? !up_level : up_level;
			end else if (match) begin
				// direction picks action, BOTTOM counts as up
				oc_q <= (up_q || at_bottom) ? up_level : !up_level;
			end
		end
	end

	// pin drive gated by direction bit
	assign OC_PIN_OUT = oc_q;
	assign OC_PIN_OE_N = !(ddr_q && (com_q != T8PWM_COM_NONE));

	// ==========================================================
	// checks
	sequence s_fast_wrap;
		fast && tick && at_max && !wr_cnt;
	endsequence

	sequence s_phase_top;
		phase && tick && at_max && up_q && !wr_cnt;
	endsequence

	a_fast_wrap: assert property (@(posedge CLK) disable iff (!RESETN)
		s_fast_wrap |=> cnt_q == T8PWM_BOTTOM)
		else $error("counter did not wrap to bottom");

	a_fast_ovf: assert property (@(posedge CLK) disable iff (!RESETN)
		s_fast_wrap |=> ovf_q)
		else $error("overflow flag missing at max");

	a_phase_turn: assert property (@(posedge CLK) disable iff (!RESETN)
		s_phase_top |=> !up_q && cnt_q == 8'hfe)
		else $error("dual-slope did not reverse at max");

	a_phase_ovf: assert property (@(posedge CLK) disable iff (!RESETN)
		phase && tick && at_bottom |=> ovf_q)
		else $error("overflow flag missing at bottom");

	a_fast_set: assert property (@(posedge CLK) disable iff (!RESETN)
		(s_fast_wrap and (com_q == T8PWM_COM_NONINV)) ##1 (com_q == T8PWM_COM_NONINV)
		|-> oc_q)
		else $error("output not set at bottom");

	a_match_flag: assert property (@(posedge CLK) disable iff (!RESETN)
		tick && !block_q && cnt_q == ocr_q |=> cmp_q)
		else $error("match flag not set");

	a_write_block: assert property (@(posedge CLK) disable iff (!RESETN)
		wr_cnt |=> !match)
		else $error("match not blocked after count write");

	a_no_action: assert property (@(posedge CLK) disable iff (!RESETN)
		com_q == T8PWM_COM_NONE ##1 com_q == T8PWM_COM_NONE |-> $stable(oc_q))
		else $error("output changed with no action");

	a_pin_gate: assert property (@(posedge CLK) disable iff (!RESETN)
		!ddr_q |-> OC_PIN_OE_N)
		else $error("pin driven while input");

	a_buf_load: assert property (@(posedge CLK) disable iff (!RESETN)
		(fast || phase) && !load_ocr && !wr_ctrl |=> $stable(ocr_q))
		else $error("compare loaded outside update point");

	a_stopped: assert property (@(posedge CLK) disable iff (!RESETN)
		cs_q == 3'h0 && !wr_cnt |=> $stable(cnt_q))
		else $error("counter moved while stopped");

endmodule

// ===== bench/t8pwm_load.sv
// external load on the compare output pin, with a pull-down
// assumes the pin lines of t8pwm_top and the bench clock
`timescale 1ns/1ps
module t8pwm_load (
	// clock and measurement control
	input wire logic clk,
	input wire logic clr,
	// pin lines
	input wire logic pin_out,
	input wire logic pin_oe_n,
	// measurements
	output logic pin_level,
	output int high_cnt,
	output int rise_cnt
);
	logic last_q;

	// =========
	// pin level
	// a released pin falls to the pull-down level
	assign pin_level = pin_oe_n ? 1'b0 : pin_out;

	// =========
	// duty and edge counters
	always_ff @(posedge clk) begin
		last_q <= pin_level;
		if (clr) begin
			high_cnt <= 0;
			rise_cnt <= 0;
		end else begin
			high_cnt <= high_cnt + (pin_level ? 1 : 0);
			rise_cnt <= rise_cnt + ((pin_level && !last_q) ? 1 : 0);
		end
	end
endmodule

// ===== bench/tb.sv
// self-checking bench for the 8-bit pwm timer block
// assumes t8pwm_pkg, t8pwm_top and the t8pwm_load model
`timescale 1ns/1ps
module tb;
	import t8pwm_pkg::*;
	logic CLK = 1'b0;
	logic RESETN = 1'b0;
	logic [4:0] AVS_ADDRESS = 5'h00;
	logic AVS_READ = 1'b0;
	logic AVS_WRITE = 1'b0;
	logic [31:0] AVS_WRITEDATA = 32'h0;
	logic [3:0] AVS_BYTEENABLE = 4'h0;
	logic [31:0] AVS_READDATA;
	logic AVS_WAITREQUEST;
	logic OSC_IN = 1'b0;
	logic OC_PIN_OUT;
	logic OC_PIN_OE_N;
	logic osc_en = 1'b0;
	logic clr = 1'b0;
	logic pin_level;
	int high_cnt;
	int rise_cnt;
	int fails = 0;
	int comparisons = 0;
	logic [31:0] rd;
	localparam logic [1:0] md_fast = T8PWM_MODE_FAST;
	localparam logic [1:0] md_phase = T8PWM_MODE_PHASE;
	localparam logic [1:0] com_ni = T8PWM_COM_NONINV;
	localparam logic [1:0] com_inv = T8PWM_COM_INV;
	localparam logic [1:0] com_tog = T8PWM_COM_TOGGLE;

	// =========
	// clocks
	always #12.5 CLK = ~CLK;
	// oscillator at eight CLK periods, its edges on CLK falling edges, kept away from CLK rising edges
	always #100 if (osc_en) OSC_IN = ~OSC_IN;

	// =========
	// instances
	t8pwm_top u_dut (.CLK(CLK), .RESETN(RESETN), .AVS_ADDRESS(AVS_ADDRESS),
		.AVS_READ(AVS_READ), .AVS_WRITE(AVS_WRITE), .AVS_WRITEDATA(AVS_WRITEDATA),
		.AVS_BYTEENABLE(AVS_BYTEENABLE), .AVS_READDATA(AVS_READDATA),
		.AVS_WAITREQUEST(AVS_WAITREQUEST), .OSC_IN(OSC_IN), .OC_PIN_OUT(OC_PIN_OUT),
		.OC_PIN_OE_N(OC_PIN_OE_N));
	t8pwm_load u_load (.clk(CLK), .clr(clr), .pin_out(OC_PIN_OUT), .pin_oe_n(OC_PIN_OE_N),
		.pin_level(pin_level), .high_cnt(high_cnt), .rise_cnt(rise_cnt));

	// =========
	// reporting
	task automatic print_verdict();
		$display("fails=%0d comparisons=%0d", fails, comparisons);
		if (fails == 0 && comparisons > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			fails++;
			$display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	// =========
	// avalon-mm access
	task automatic bus(input logic wr, input logic [4:0] adr, input logic [31:0] wd,
		input logic [3:0] be);
		int i;
		@(posedge CLK);
		AVS_ADDRESS <= adr;
		AVS_WRITEDATA <= wd;
		AVS_BYTEENABLE <= be;
		AVS_WRITE <= wr;
		AVS_READ <= !wr;
		for (i = 0; i < 16; i++) begin
			@(posedge CLK);
			if (AVS_WAITREQUEST === 1'b0) begin
				break;
			end
		end
		rd = AVS_READDATA;
		AVS_WRITE <= 1'b0;
		AVS_READ <= 1'b0;
		if (i == 16) begin
			fails++;
			print_verdict();
		end
	endtask

	task automatic wr(input logic [4:0] adr, input logic [31:0] wd);
		bus(1'b1, adr, wd, 4'h1);
	endtask

	task automatic rdc(input logic [4:0] adr, input logic [31:0] exp);
		bus(1'b0, adr, 32'h0, 4'h0);
		check(rd, exp);
	endtask

	function automatic logic [31:0] mk(input logic a, input logic [2:0] cs,
		input logic [1:0] com, input logic [1:0] md);
		return {24'h0, a, cs, com, md};
	endfunction

	// =========
	// waveform measurement over n cycles once settled
	task automatic run_case(input logic [1:0] md, input logic [1:0] com, input logic [2:0] cs,
		input logic a, input logic [7:0] ocr, input int n, input int hi, input int ris,
		input int tol);
		wr(T8PWM_OFS_CTRL, mk(a, cs, com, md));
		wr(T8PWM_OFS_COMPARE, {24'h0, ocr});
		wr(T8PWM_OFS_PIN, 32'h1);
		repeat (2 * n + 8) @(posedge CLK);
		@(posedge CLK);
		clr <= 1'b1;
		@(posedge CLK);
		clr <= 1'b0;
		repeat (n) @(posedge CLK);
		@(negedge CLK);
		check(32'((high_cnt >= hi - tol) && (high_cnt <= hi + tol)), 32'h1);
		check(32'(rise_cnt), 32'(ris));
		check(32'(OC_PIN_OE_N), 32'h0);
	endtask

	// =========
	// flags after starting from a written count
	task automatic flag_case(input logic [1:0] md, input logic [7:0] start, input int w,
		input logic [31:0] exp);
		wr(T8PWM_OFS_CTRL, mk(1'b0, 3'h0, T8PWM_COM_NONE, md));
		wr(T8PWM_OFS_COUNT, {24'h0, start});
		wr(T8PWM_OFS_STATUS, 32'h3);
		wr(T8PWM_OFS_CTRL, mk(1'b0, 3'h1, T8PWM_COM_NONE, md));
		repeat (w) @(posedge CLK);
		bus(1'b0, T8PWM_OFS_STATUS, 32'h0, 4'h0);
		check(rd & 32'h3, exp);
		check(32'(OC_PIN_OE_N), 32'h1);
	endtask

	// =========
	// main sequence
	initial begin
		repeat (8) @(posedge CLK);
		RESETN <= 1'b1;
		check(32'(OC_PIN_OE_N), 32'h1);
		check(32'(OC_PIN_OUT), 32'h0);
		rdc(T8PWM_OFS_CTRL, 32'(T8PWM_CTRL_RESET));
		rdc(T8PWM_OFS_COUNT, 32'(T8PWM_COUNT_RESET));
		rdc(T8PWM_OFS_COMPARE, 32'(T8PWM_COMPARE_RESET));
		rdc(5'h14, 32'h0);
		bus(1'b1, T8PWM_OFS_COMPARE, 32'ha5, 4'h0);
		rdc(T8PWM_OFS_COMPARE, 32'h0);
		wr(T8PWM_OFS_COMPARE, 32'h5a);
		rdc(T8PWM_OFS_COMPARE, 32'h5a);
		run_case(md_fast, com_ni, 3'h1, 1'b0, 8'h40, 256, 65, 1, 0);
		run_case(md_fast, com_inv, 3'h1, 1'b0, 8'h40, 256, 191, 1, 0);
		flag_case(T8PWM_MODE_FAST, 8'h40, 20, 32'h0);
		flag_case(T8PWM_MODE_FAST, 8'h3c, 20, 32'h2);
		flag_case(T8PWM_MODE_FAST, 8'hf0, 30, 32'h1);
		flag_case(T8PWM_MODE_PHASE, 8'hf0, 30, 32'h0);
		flag_case(T8PWM_MODE_PHASE, 8'h30, 600, 32'h3);
		run_case(md_fast, com_ni, 3'h1, 1'b0, 8'h00, 256, 1, 1, 0);
		run_case(md_fast, com_ni, 3'h1, 1'b0, 8'hff, 256, 256, 0, 0);
		wr(T8PWM_OFS_PIN, 32'h0);
		// let the direction write settle before looking at the pin
		@(negedge CLK);
		check(32'(OC_PIN_OE_N), 32'h1);
		check(32'(pin_level), 32'h0);
		// level high, counting up, both flags left set by the runs before
		rdc(T8PWM_OFS_STATUS, 32'hf);
		run_case(md_fast, com_inv, 3'h1, 1'b0, 8'hff, 256, 0, 0, 0);
		run_case(md_fast, com_tog, 3'h1, 1'b0, 8'h00, 512, 256, 1, 0);
		run_case(md_fast, com_ni, 3'h2, 1'b0, 8'h3f, 2048, 512, 1, 0);
		run_case(md_fast, com_ni, 3'h3, 1'b0, 8'h3f, 8192, 2048, 1, 0);
		run_case(md_phase, com_ni, 3'h1, 1'b0, 8'h40, 510, 128, 1, 0);
		run_case(md_phase, com_inv, 3'h1, 1'b0, 8'h40, 510, 382, 1, 0);
		run_case(md_phase, com_ni, 3'h1, 1'b0, 8'h00, 510, 0, 0, 0);
		run_case(md_phase, com_ni, 3'h1, 1'b0, 8'hff, 510, 510, 0, 0);
		run_case(md_phase, com_inv, 3'h1, 1'b0, 8'h00, 510, 510, 0, 0);
		osc_en = 1'b1;
		run_case(md_fast, com_ni, 3'h1, 1'b1, 8'h7f, 2048, 1024, 1, 8);
		osc_en = 1'b0;
		print_verdict();
	end
endmodule
